// File: lsr_top.sv
// Limit switch reaction, hardware information and special mode objects.
// Assumes switch pins are asynchronous; all other inputs share the clock.
`timescale 1ns/100ps
// How it works
// RL1: A switch trip latches the position and sets status word bit 7 warning.
// RL2: A trip with code 1, 2, 5 or 6 moves the power state to quick stop active and runs the reaction.
// RL3: Reaction code is signed 16-bit, default -1: no stop, keep latched position.
// RL4: Code -2 takes no stop and discards the latched position.
// RL5: Code 0 cuts the power stage at once and enters switch on disabled.
// RL6: Codes 1 and 2 brake on slow or quick ramp, then switch on disabled.
// RL7: Codes 5 and 6 brake, then hold quick stop energised; re-enable allowed.
// RL8: Hardware info reports memory size in bytes, read-only; zero means none.
// RL9: Five read-only signed entries; 1 and 2 are supply voltages in mV.
// RL10: Entry 3 board temperature, 5 processor temperature in tenths; 4 reserved.
// RL11: One read/write 32-bit configuration word, default zero, no function.
// RL12: An object switches the special drive modes on or off.
// RL13: Writing 0 turns special modes off, 2 on with mode from entry 2.
// RL14: Reaction codes outside the defined set are rejected, old value kept.
module lsr_top
    import lsr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Object access port
    input wire logic obj_rd,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_ack,
    output logic obj_err,
    // Limit switch pins and motion inputs
    input wire logic [NUM_SWITCHES-1:0] limit_sw,
    input wire logic [31:0] actual_position,
    input wire logic ramp_done,
    input wire logic enable_req,
    input wire logic warning_clear,
    // Measurements and hardware facts
    input wire logic [31:0] nvm_size_bytes,
    input wire logic [31:0] power_supply_voltage,
    input wire logic [31:0] logic_supply_voltage,
    input wire logic [31:0] board_temperature,
    input wire logic [31:0] cpu_temperature,
    // Drive outputs
    output logic [15:0] status_word,
    output logic [31:0] limit_position,
    output logic limit_position_valid,
    output lsr_power_type power_state,
    output logic power_stage_on,
    output logic ramp_slow,
    output logic ramp_quick,
    output logic special_modes_on,
    output logic [7:0] special_mode_sel,
    output logic [31:0] hardware_config_word
);
    lsr_react_if rif ();

    logic [NUM_SWITCHES-1:0] sync1_q;
    logic [NUM_SWITCHES-1:0] sync2_q;
    logic [NUM_SWITCHES-1:0] sync3_q;
    logic [NUM_SWITCHES-1:0] level_q;
    logic [NUM_SWITCHES-1:0] level_d;
    logic [NUM_SWITCHES-1:0] rise;
    logic [15:0] code_q;
    logic [31:0] hwcfg_q;
    logic [7:0] spcfg_q;
    logic [7:0] spsel_q;
    logic spon_q;
    logic warn_q;
    logic [31:0] pos_q;
    logic pos_valid_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic err_q;

    // Three-stage sync; a level counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SWITCHES; gi = gi + 1) begin : g_sw
            assign level_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : level_q[gi];
            assign rise[gi] = level_d[gi] && !level_q[gi];
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
            level_q <= '0;
        end else begin
            sync1_q <= limit_sw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            level_q <= level_d;
        end
    end

    wire logic trip = |rise;

    // Access decode
    wire logic hit_code = (obj_index == IDX_LIMIT_CODE) && (obj_sub == SUB_COUNT);
    wire logic hit_info = obj_index == IDX_HW_INFO;
    wire logic hit_cfg = obj_index == IDX_HW_CONFIG;
    wire logic hit_cond = obj_index == IDX_OP_COND;
    wire logic hit_spec = obj_index == IDX_SPECIAL;
    wire logic [15:0] wcode = obj_wdata[15:0];
    wire logic code_ok = (wcode == CODE_DISCARD) || (wcode == CODE_KEEP) ||
                         (wcode == CODE_COAST) || (wcode == CODE_SLOW_SOD) ||
                         (wcode == CODE_QUICK_SOD) || (wcode == CODE_SLOW_QSA) ||
                         (wcode == CODE_QUICK_QSA); // see RL14
    wire logic sp_ok = (obj_wdata[7:0] == SPECIAL_OFF) || (obj_wdata[7:0] == SPECIAL_ON);
    wire logic wr_code = obj_wr && hit_code && code_ok;
    wire logic wr_cfg = obj_wr && hit_cfg && (obj_sub == SUB_1);
    wire logic wr_spcfg = obj_wr && hit_spec && (obj_sub == SUB_1) && sp_ok;
    wire logic wr_spsel = obj_wr && hit_spec && (obj_sub == SUB_2);
    wire logic wr_ok = wr_code || wr_cfg || wr_spcfg || wr_spsel;

    // Read mux; reserved entry 4 reads zero
    logic [31:0] rd_val;
    logic rd_hit;
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        if (hit_code) begin
            rd_val = {{16{code_q[15]}}, code_q};
        end else if (hit_info && (obj_sub == SUB_COUNT)) begin
            rd_val = HW_INFO_ENTRIES;
        end else if (hit_info && (obj_sub == SUB_1)) begin
            rd_val = nvm_size_bytes; // see RL8
        end else if (hit_cfg && (obj_sub == SUB_COUNT)) begin
            rd_val = HW_CONFIG_ENTRIES;
        end else if (hit_cfg && (obj_sub == SUB_1)) begin
            rd_val = hwcfg_q; // see RL11
        end else if (hit_cond && (obj_sub == SUB_COUNT)) begin
            rd_val = OP_COND_ENTRIES; // see RL9
        end else if (hit_cond && (obj_sub == SUB_1)) begin
            rd_val = power_supply_voltage; // see RL9
        end else if (hit_cond && (obj_sub == SUB_2)) begin
            rd_val = logic_supply_voltage; // see RL9
        end else if (hit_cond && (obj_sub == SUB_3)) begin
            rd_val = board_temperature; // see RL10
        end else if (hit_cond && (obj_sub == SUB_4)) begin
            rd_val = 32'h0000_0000; // see RL10
        end else if (hit_cond && (obj_sub == SUB_5)) begin
            rd_val = cpu_temperature; // see RL10
        end else if (hit_spec && (obj_sub == SUB_COUNT)) begin
            rd_val = SPECIAL_ENTRIES;
        end else if (hit_spec && (obj_sub == SUB_1)) begin
            rd_val = {24'h00_0000, spcfg_q};
        end else if (hit_spec && (obj_sub == SUB_2)) begin
            rd_val = {24'h00_0000, spsel_q};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Writable objects; invalid values leave the old setting
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            code_q <= LIMIT_CODE_RESET; // see RL3
            hwcfg_q <= HW_CONFIG_RESET; // see RL11
            spcfg_q <= SPECIAL_CFG_RESET;
            spsel_q <= SPECIAL_SEL_RESET;
            spon_q <= 1'b0;
        end else begin
            if (wr_code) code_q <= wcode; // see RL3
            if (wr_cfg) hwcfg_q <= obj_wdata; // see RL11
            if (wr_spcfg) spcfg_q <= obj_wdata[7:0]; // see RL13
            if (wr_spcfg) spon_q <= obj_wdata[7:0] == SPECIAL_ON; // see RL13
            if (wr_spsel) spsel_q <= obj_wdata[7:0]; // see RL12
        end
    end

    // Access answer, one cycle after the request
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0000_0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            rdata_q <= obj_rd ? rd_val : 32'h0000_0000;
            ack_q <= (obj_rd && rd_hit) || wr_ok;
            err_q <= (obj_rd && !rd_hit) || (obj_wr && !wr_ok);
        end
    end

    // Warning and position latch; a trip beats a clear in the same cycle
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            warn_q <= 1'b0;
            pos_q <= 32'h0000_0000;
            pos_valid_q <= 1'b0;
        end else begin
            if (trip) warn_q <= 1'b1; // see RL1
            else if (warning_clear) warn_q <= 1'b0;
            if (trip && (code_q == CODE_DISCARD)) begin
                pos_valid_q <= 1'b0; // see RL4
            end else if (trip) begin
                pos_q <= actual_position; // see RL1
                pos_valid_q <= 1'b1; // see RL3
            end
        end
    end

    // Hand the trip to the sequencer
    assign rif.trip = trip; // see RL2
    assign rif.code = code_q;
    assign rif.ramp_done = ramp_done;
    assign rif.enable_req = enable_req;

    lsr_react_seq u_seq (
        .clock(clock),
        .rst_b(rst_b),
        .rif(rif)
    );

    assign obj_rdata = rdata_q;
    assign obj_ack = ack_q;
    assign obj_err = err_q;
    assign status_word = {8'h00, warn_q, 7'h00} >> (7 - WARNING_BIT);
    assign limit_position = pos_q;
    assign limit_position_valid = pos_valid_q;
    assign power_state = rif.power_state;
    assign power_stage_on = rif.stage_on;
    assign ramp_slow = rif.ramp_slow;
    assign ramp_quick = rif.ramp_quick;
    assign special_modes_on = spon_q; // see RL13
    assign special_mode_sel = spsel_q;
    assign hardware_config_word = hwcfg_q;
endmodule : lsr_top

// File: lsr_pkg.sv
// Constants, object map and state types for the limit switch reaction block.
// Assumes a single 10 MHz clock domain shared by every user of this package.
package lsr_pkg;
    // Object indices and subindices
    localparam logic [15:0] IDX_LIMIT_CODE = 16'h3701;
    localparam logic [15:0] IDX_HW_INFO = 16'h4012;
    localparam logic [15:0] IDX_HW_CONFIG = 16'h4013;
    localparam logic [15:0] IDX_OP_COND = 16'h4014;
    localparam logic [15:0] IDX_SPECIAL = 16'h4015;
    localparam logic [7:0] SUB_COUNT = 8'h00;
    localparam logic [7:0] SUB_1 = 8'h01;
    localparam logic [7:0] SUB_2 = 8'h02;
    localparam logic [7:0] SUB_3 = 8'h03;
    localparam logic [7:0] SUB_4 = 8'h04;
    localparam logic [7:0] SUB_5 = 8'h05;
    // Entry counts read at subindex 0
    localparam logic [31:0] HW_INFO_ENTRIES = 32'h0000_0001;
    localparam logic [31:0] HW_CONFIG_ENTRIES = 32'h0000_0001;
    localparam logic [31:0] OP_COND_ENTRIES = 32'h0000_0005;
    localparam logic [31:0] SPECIAL_ENTRIES = 32'h0000_0002;
    // Reset values
    localparam logic [15:0] LIMIT_CODE_RESET = 16'hFFFF;
    localparam logic [31:0] HW_CONFIG_RESET = 32'h0000_0000;
    localparam logic [7:0] SPECIAL_CFG_RESET = 8'h00;
    localparam logic [7:0] SPECIAL_SEL_RESET = 8'h00;
    // Special drive mode switch values
    localparam logic [7:0] SPECIAL_OFF = 8'h00;
    localparam logic [7:0] SPECIAL_ON = 8'h02;
    // Limit switch reaction codes
    localparam logic [15:0] CODE_DISCARD = 16'hFFFE;
    localparam logic [15:0] CODE_KEEP = 16'hFFFF;
    localparam logic [15:0] CODE_COAST = 16'h0000;
    localparam logic [15:0] CODE_SLOW_SOD = 16'h0001;
    localparam logic [15:0] CODE_QUICK_SOD = 16'h0002;
    localparam logic [15:0] CODE_SLOW_QSA = 16'h0005;
    localparam logic [15:0] CODE_QUICK_QSA = 16'h0006;
    // Status word warning bit
    localparam int WARNING_BIT = 7;
    // Number of limit switch inputs
    localparam int NUM_SWITCHES = 2;

    // Power state as seen from outside
    typedef enum logic [1:0] {
        PS_SWITCH_ON_DISABLED,
        PS_OPERATION_ENABLED,
        PS_QUICK_STOP_ACTIVE
    } lsr_power_type;
endpackage : lsr_pkg

// File: lsr_react_if.sv
// Carrier between the object dictionary and the stop reaction sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface lsr_react_if;
    import lsr_pkg::*;
    logic trip;
    logic [15:0] code;
    logic ramp_done;
    logic enable_req;
    lsr_power_type power_state;
    logic stage_on;
    logic ramp_slow;
    logic ramp_quick;

    modport ctrl (output trip, output code, output ramp_done, output enable_req,
                  input power_state, input stage_on, input ramp_slow, input ramp_quick);
    modport seq (input trip, input code, input ramp_done, input enable_req,
                 output power_state, output stage_on, output ramp_slow, output ramp_quick);
endinterface : lsr_react_if

// File: lsr_react_seq.sv
// Stop reaction sequencer: power state, power stage and ramp requests.
// Assumes the trip pulse is synchronous and the reaction code already valid.
`timescale 1ns/100ps
module lsr_react_seq
    import lsr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Reaction carrier
    lsr_react_if.seq rif
);
    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_BRAKE,
        SQ_HOLD
    } lsr_seq_type;

    lsr_seq_type seq_q;
    lsr_seq_type seq_d;
    lsr_power_type ps_q;
    lsr_power_type ps_d;
    logic stage_q;
    logic stage_d;
    logic slow_q;
    logic slow_d;
    logic quick_q;
    logic quick_d;
    logic [15:0] code_q;
    logic [15:0] code_d;

    // Classify the code frozen at the trip
    wire logic code_ramp = (rif.code == CODE_SLOW_SOD) || (rif.code == CODE_QUICK_SOD) ||
                           (rif.code == CODE_SLOW_QSA) || (rif.code == CODE_QUICK_QSA);
    wire logic code_slow = (rif.code == CODE_SLOW_SOD) || (rif.code == CODE_SLOW_QSA);
    wire logic held_stays = (code_q == CODE_SLOW_QSA) || (code_q == CODE_QUICK_QSA);
    wire logic trip_live = rif.trip && (ps_q == PS_OPERATION_ENABLED);

    // Next state; a trip only acts while operating
    always_comb begin
        seq_d = seq_q;
        ps_d = ps_q;
        stage_d = stage_q;
        slow_d = slow_q;
        quick_d = quick_q;
        code_d = code_q;
        case (seq_q)
            SQ_IDLE: begin
                if (trip_live && (rif.code == CODE_COAST)) begin
                    ps_d = PS_SWITCH_ON_DISABLED; // see RL5
                    stage_d = 1'b0; // see RL5
                end else if (trip_live && code_ramp) begin
                    ps_d = PS_QUICK_STOP_ACTIVE; // see RL2
                    seq_d = SQ_BRAKE;
                    code_d = rif.code;
                    slow_d = code_slow; // see RL6
                    quick_d = !code_slow; // see RL6
                end else if (rif.enable_req && (ps_q == PS_SWITCH_ON_DISABLED)) begin
                    ps_d = PS_OPERATION_ENABLED;
                    stage_d = 1'b1;
                end
            end
            SQ_BRAKE: begin
                if (rif.ramp_done) begin
                    slow_d = 1'b0;
                    quick_d = 1'b0;
                    if (held_stays) begin
                        seq_d = SQ_HOLD; // see RL7
                    end else begin
                        seq_d = SQ_IDLE;
                        ps_d = PS_SWITCH_ON_DISABLED; // see RL6
                        stage_d = 1'b0;
                    end
                end
            end
            SQ_HOLD: begin
                // Motor stays energised until operation is re-enabled
                if (rif.enable_req) begin
                    seq_d = SQ_IDLE;
                    ps_d = PS_OPERATION_ENABLED; // see RL7
                end
            end
            default: begin
                seq_d = SQ_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            seq_q <= SQ_IDLE;
            ps_q <= PS_SWITCH_ON_DISABLED;
            stage_q <= 1'b0;
            slow_q <= 1'b0;
            quick_q <= 1'b0;
            code_q <= LIMIT_CODE_RESET;
        end else begin
            seq_q <= seq_d;
            ps_q <= ps_d;
            stage_q <= stage_d;
            slow_q <= slow_d;
            quick_q <= quick_d;
            code_q <= code_d;
        end
    end

    assign rif.power_state = ps_q;
    assign rif.stage_on = stage_q;
    assign rif.ramp_slow = slow_q;
    assign rif.ramp_quick = quick_q;
endmodule : lsr_react_seq

// File: lsr_top_sva.sv
// Port-level checks for the limit switch reaction block.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/100ps
module lsr_top_sva
    import lsr_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Object access
    input wire logic obj_rd,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [31:0] obj_wdata,
    input wire logic [31:0] obj_rdata,
    input wire logic obj_ack,
    input wire logic obj_err,
    // Drive side
    input wire logic [NUM_SWITCHES-1:0] limit_sw,
    input wire logic ramp_done,
    input wire logic [31:0] nvm_size_bytes,
    input wire logic [15:0] status_word,
    input wire lsr_power_type power_state,
    input wire logic power_stage_on,
    input wire logic ramp_slow,
    input wire logic ramp_quick,
    input wire logic special_modes_on,
    input wire logic [31:0] hardware_config_word
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // Access decode; code set kept here so a widened set shows up
    wire logic lc_wr = obj_wr && obj_index == IDX_LIMIT_CODE && obj_sub == SUB_COUNT;
    wire logic code_ok = obj_wdata[15:0] inside {CODE_DISCARD, CODE_KEEP, CODE_COAST,
        CODE_SLOW_SOD, CODE_QUICK_SOD, CODE_SLOW_QSA, CODE_QUICK_QSA};
    wire logic ramping = ramp_slow || ramp_quick;
    // Single-cycle pieces of a stop reaction
    sequence s_trip;
        $rose(limit_sw[0]) || $rose(limit_sw[1]);
    endsequence
    sequence s_ramp_end;
        ramping && ramp_done;
    endsequence
    property p_answer;
        (obj_rd || obj_wr) |=> (obj_ack ^ obj_err);
    endproperty
    a_answer: assert property (p_answer) else $error("access answer missing");
    property p_quiet;
        !(obj_rd || obj_wr) |=> !obj_ack && !obj_err && obj_rdata == 32'h0;
    endproperty
    a_quiet: assert property (p_quiet) else $error("answer without access");
    property p_bad_code;
        lc_wr && !code_ok |=> obj_err;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code accepted");
    property p_ro_write;
        obj_wr && (obj_index == IDX_HW_INFO || obj_index == IDX_OP_COND) |=> obj_err;
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only written");
    property p_hw_read;
        obj_rd && obj_index == IDX_HW_INFO && obj_sub == SUB_1
            |=> obj_ack && obj_rdata == $past(nvm_size_bytes);
    endproperty
    a_hw_read: assert property (p_hw_read) else $error("memory size wrong");
    property p_cfg_write;
        obj_wr && obj_index == IDX_HW_CONFIG && obj_sub == SUB_1
            |=> obj_ack && hardware_config_word == $past(obj_wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config not stored");
    property p_special_on;
        obj_wr && obj_index == IDX_SPECIAL && obj_sub == SUB_1 && obj_wdata == 32'h2
            |=> special_modes_on;
    endproperty
    a_special_on: assert property (p_special_on) else $error("modes not on");
    property p_warn;
        s_trip |-> ##[1:6] status_word[WARNING_BIT];
    endproperty
    a_warn: assert property (p_warn) else $error("no warning after trip");
    property p_ramp_in;
        $rose(ramping) |-> power_state == PS_QUICK_STOP_ACTIVE && power_stage_on;
    endproperty
    a_ramp_in: assert property (p_ramp_in) else $error("ramp outside quick stop");
    property p_ramp_out;
        s_ramp_end |=> !ramping && (power_state == PS_SWITCH_ON_DISABLED
            || (power_state == PS_QUICK_STOP_ACTIVE && power_stage_on));
    endproperty
    a_ramp_out: assert property (p_ramp_out) else $error("bad ramp end");
    property p_coast;
        power_state == PS_SWITCH_ON_DISABLED |-> !power_stage_on && !ramping;
    endproperty
    a_coast: assert property (p_coast) else $error("stage on while disabled");
endmodule : lsr_top_sva

bind lsr_top lsr_top_sva i_sva (.*);

// File: lsr_motion_model.sv
// Motion side model: answers ramp requests, moves the position.
// Assumes the block's clock; ramp_done pulses one cycle per ramp.
`timescale 1ns/100ps
module lsr_motion_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Ramp handshake and its length in cycles
    input wire logic ramp_slow,
    input wire logic ramp_quick,
    input wire logic [3:0] ramp_len,
    output logic ramp_done,
    output logic [31:0] actual_position
);
    logic [3:0] cnt_q;
    wire logic busy = (ramp_slow || ramp_quick) && !ramp_done;
    // One-cycle pulse; a request held high is answered again every ramp_len + 2 cycles
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 4'h0;
            ramp_done <= 1'b0;
            actual_position <= 32'h0;
        end else begin
            actual_position <= actual_position + 32'h1;
            ramp_done <= busy && cnt_q == ramp_len;
            cnt_q <= busy ? cnt_q + 4'h1 : 4'h0;
        end
    end
endmodule : lsr_motion_model

// File: tb_top.sv
// Self-checking bench for the limit switch reaction block.
// Assumes the motion model answers ramps; the bench is master and switch.
`timescale 1ns/100ps
module tb_top;
    import lsr_pkg::*;
    // Access row: inputs beside the answer they should give
    typedef struct packed {
        logic wr;
        logic [15:0] idx;
        logic [7:0] sub;
        logic [31:0] wd;
        logic err;
        logic [31:0] rd;
    } lsr_row_type;
    localparam logic [31:0] NVM = 32'h0000_2000;
    localparam logic [31:0] PSV = 32'h0000_5DC0;
    localparam logic [31:0] LSV = 32'h0000_5DBF;
    localparam logic [31:0] BT = 32'h0000_00FA;
    localparam logic [31:0] CT = 32'hFFFF_FFEC;
    localparam lsr_row_type ROWS [0:20] = '{
        '{1'b0, IDX_LIMIT_CODE, SUB_COUNT, 32'h0, 1'b0, 32'hFFFF_FFFF},
        '{1'b1, IDX_LIMIT_CODE, SUB_COUNT, 32'h3, 1'b1, 32'h0},
        '{1'b1, IDX_LIMIT_CODE, SUB_COUNT, 32'hFFFD, 1'b1, 32'h0},
        '{1'b0, IDX_LIMIT_CODE, SUB_COUNT, 32'h0, 1'b0, 32'hFFFF_FFFF},
        '{1'b0, IDX_HW_INFO, SUB_COUNT, 32'h0, 1'b0, 32'h1},
        '{1'b0, IDX_HW_INFO, SUB_1, 32'h0, 1'b0, NVM},
        '{1'b1, IDX_HW_INFO, SUB_1, 32'h5, 1'b1, 32'h0},
        '{1'b0, IDX_HW_CONFIG, SUB_1, 32'h0, 1'b0, 32'h0},
        '{1'b1, IDX_HW_CONFIG, SUB_1, 32'hA5A5_0F0F, 1'b0, 32'h0},
        '{1'b0, IDX_OP_COND, SUB_COUNT, 32'h0, 1'b0, 32'h5},
        '{1'b0, IDX_OP_COND, SUB_1, 32'h0, 1'b0, PSV},
        '{1'b0, IDX_OP_COND, SUB_2, 32'h0, 1'b0, LSV},
        '{1'b0, IDX_OP_COND, SUB_3, 32'h0, 1'b0, BT},
        '{1'b0, IDX_OP_COND, SUB_4, 32'h0, 1'b0, 32'h0},
        '{1'b0, IDX_OP_COND, SUB_5, 32'h0, 1'b0, CT},
        '{1'b1, IDX_OP_COND, SUB_1, 32'h7, 1'b1, 32'h0},
        '{1'b1, IDX_SPECIAL, SUB_1, 32'h2, 1'b0, 32'h0},
        '{1'b1, IDX_SPECIAL, SUB_1, 32'h1, 1'b1, 32'h0},
        '{1'b1, IDX_SPECIAL, SUB_2, 32'h3, 1'b0, 32'h0},
        '{1'b0, IDX_SPECIAL, SUB_1, 32'h0, 1'b0, 32'h2},
        '{1'b0, 16'h5000, SUB_COUNT, 32'h0, 1'b1, 32'h0}};
    localparam logic [15:0] CODES [0:6] = '{CODE_KEEP, CODE_DISCARD, CODE_COAST,
        CODE_SLOW_SOD, CODE_QUICK_SOD, CODE_SLOW_QSA, CODE_QUICK_QSA};
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic obj_rd = 1'b0;
    logic obj_wr = 1'b0;
    logic [15:0] obj_index = 16'h0;
    logic [7:0] obj_sub = 8'h0;
    logic [31:0] obj_wdata = 32'h0;
    logic [NUM_SWITCHES-1:0] limit_sw = '0;
    logic enable_req = 1'b0;
    logic warning_clear = 1'b0;
    logic [3:0] ramp_len = 4'h0;
    logic [31:0] obj_rdata, actual_position, limit_position, hardware_config_word;
    logic [15:0] status_word;
    logic [7:0] special_mode_sel;
    logic obj_ack, obj_err, ramp_done, limit_position_valid, power_stage_on;
    logic ramp_slow, ramp_quick, special_modes_on;
    lsr_power_type power_state;
    wire logic [2:0] watch = {ramp_quick, ramp_slow, status_word[WARNING_BIT]};
    int num_errors = 0;
    int n_tests = 0;
    // Design and motion side
    lsr_top i_dut (.nvm_size_bytes(NVM), .power_supply_voltage(PSV),
        .logic_supply_voltage(LSV), .board_temperature(BT), .cpu_temperature(CT), .*);
    lsr_motion_model i_motion (.*);
    always #50 clock = ~clock;
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check
    // Inputs move 1 ns after the edge so no race with the design's sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    // One-cycle request, answer taken one edge later
    task automatic access(input lsr_row_type r);
        obj_rd = !r.wr;
        obj_wr = r.wr;
        obj_index = r.idx;
        obj_sub = r.sub;
        obj_wdata = r.wd;
        tick(1);
        obj_rd = 1'b0;
        obj_wr = 1'b0;
        check("err", 32'(r.err), 32'(obj_err));
        check("ack", 32'(!r.err), 32'(obj_ack));
        if (!r.wr && !r.err) check("rdata", r.rd, obj_rdata);
        tick(1);
    endtask : access
    // Bounded wait; a bound used up ends the run
    task automatic wait_until(input string what, input int b, input logic lvl);
        int k = 0;
        while (watch[b] !== lvl && k < 20) begin
            tick(1);
            k++;
        end
        if (watch[b] !== lvl) begin
            check(what, 32'(lvl), 32'(watch[b]));
            final_report();
        end
    endtask : wait_until
    // Enable, trip, follow the reaction the code selects
    task automatic trip(input logic [15:0] code, input logic [3:0] len);
        logic stops, hold, slow;
        lsr_power_type st;
        stops = !(code == CODE_KEEP || code == CODE_DISCARD);
        hold = code == CODE_SLOW_QSA || code == CODE_QUICK_QSA;
        slow = code == CODE_SLOW_SOD || code == CODE_SLOW_QSA;
        access('{1'b1, IDX_LIMIT_CODE, SUB_COUNT, {16'h0, code}, 1'b0, 32'h0});
        ramp_len = len;
        enable_req = 1'b1;
        warning_clear = 1'b1;
        tick(1);
        enable_req = 1'b0;
        warning_clear = 1'b0;
        tick(1);
        check("enabled", 32'(PS_OPERATION_ENABLED), 32'(power_state));
        check("cleared", 32'h0, 32'(status_word));
        limit_sw[code[0]] = 1'b1;
        wait_until("warning", 0, 1'b1);
        limit_sw[code[0]] = 1'b0;
        check("status", 32'h80, 32'(status_word));
        if (code != CODE_DISCARD) check("pos", actual_position - 32'h1, limit_position);
        st = !stops ? PS_OPERATION_ENABLED : code == CODE_COAST ? PS_SWITCH_ON_DISABLED
            : PS_QUICK_STOP_ACTIVE;
        check("state", 32'(st), 32'(power_state));
        check("slow", 32'(stops && code != CODE_COAST && slow), 32'(ramp_slow));
        check("quick", 32'(stops && code != CODE_COAST && !slow), 32'(ramp_quick));
        wait_until("ramp", 1, 1'b0);
        wait_until("ramp", 2, 1'b0);
        st = !stops ? PS_OPERATION_ENABLED : hold ? PS_QUICK_STOP_ACTIVE : PS_SWITCH_ON_DISABLED;
        check("end state", 32'(st), 32'(power_state));
        check("stage", 32'(!stops || hold), 32'(power_stage_on));
        check("valid", 32'(code != CODE_DISCARD), 32'(limit_position_valid));
        $display("test trip code %h done", code);
    endtask : trip
    initial begin
        tick(10);
        rst_b = 1'b1;
        tick(1);
        check("status", 32'h0, 32'(status_word));
        check("state", 32'(PS_SWITCH_ON_DISABLED), 32'(power_state));
        foreach (ROWS[i]) access(ROWS[i]);
        check("mode on", 32'h1, 32'(special_modes_on));
        check("mode sel", 32'h3, 32'(special_mode_sel));
        check("config", 32'hA5A5_0F0F, hardware_config_word);
        access('{1'b1, IDX_SPECIAL, SUB_1, 32'h0, 1'b0, 32'h0});
        check("mode off", 32'h0, 32'(special_modes_on));
        $display("test object rows done");
        foreach (CODES[i]) trip(CODES[i], i[0] ? 4'h0 : 4'h6);
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        tick(1);
        check("valid", 32'h0, 32'(limit_position_valid));
        access(ROWS[0]);
        access(ROWS[7]);
        $display("test second reset done");
        final_report();
    end
endmodule : tb_top
